// ==== include/local_expansion_bus_pkg.sv ====
`default_nettype none
package local_expansion_bus_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BCNT_W = 3;
  localparam int unsigned TCNT_W = 10;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TIMEOUT_NS     = 8000;
  localparam int unsigned TIMEOUT_CYC_I  = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [TCNT_W-1:0] TIMEOUT_CYC = TCNT_W'(TIMEOUT_CYC_I);
  localparam int unsigned BUS_CLK_DIV    = 2;

  // ==========================================================================
  // Minimum cycle width codes, in bus clocks
  localparam logic [1:0]        WIDTH_CODE_ZERO = 2'h0;
  localparam logic [BCNT_W-1:0] WIDTH_ZERO_LEN  = 3'h4;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD   = 4'h8
  } bus_state_t;

  // Processor side request
  typedef struct packed {
    logic              wr;
    logic              exp_space;
    logic              upper_byte;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  // Connector outputs
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              upper_byte_enable_n;
    logic              rd_n;
    logic              wr_n;
    logic [DATA_W-1:0] data;
    logic              data_oe;
  } bus_pins_t;

endpackage : local_expansion_bus_pkg
`default_nettype wire

// ==== logic/local_expansion_bus_master.sv ====
`timescale 1ns/10ps
`default_nettype none

// Contract
// [RULE_01] Drive 16-bit data outward on writes, accept read data inward.
// [RULE_02] Assert low upper byte enable when upper data byte takes part.
// [RULE_03] Read strobe asserts only for expansion space accesses.
// [RULE_04] Write strobe asserts only for expansion space accesses.
// [RULE_05] READY ends the current expansion access.
// [RULE_06] READY is ignored for any other local bus device.
// [RULE_07] Far device holds READY until the strobe is released.
// [RULE_08] Expansion interrupt request passes to processor interrupt input two.
// [RULE_09] Drive low system reset to connector while board reset is active.
// [RULE_10] Local bus clock is the transfer clock divided by two.
// [RULE_11] Read data latched at strobe release, data valid returned next cycle.
// [RULE_12] Overlong cycle aborts, timeout flag low until clear pulsed low-high.
// [RULE_13] Minimum cycle length in bus clocks, width code zero means four.
// [RULE_14] READY sampled on bus clock, undriven pulled-up READY counts as asserted.
// [RULE_15] Address, byte enable and write data stable while a strobe is active.
module local_expansion_bus_master
  import local_expansion_bus_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // Processor request
  input  wire logic              i_req,
  input  var  bus_req_t          i_req_info,
  input  wire logic [1:0]        i_min_width,
  input  wire logic              i_bus_timeout_clear_n,
  // Processor answer
  output logic                   o_busy,
  output logic                   o_done,
  output logic [DATA_W-1:0]      o_rdata,
  output logic                   o_cpu_data_valid_n,
  output logic                   o_bus_timeout_flag_n,
  output logic                   o_cpu_maskable_irq_input_two_n,
  // Expansion connector
  output var  bus_pins_t         o_pins,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_ready,
  input  wire logic              i_irq_n,
  output logic                   o_local_bus_clock,
  output logic                   o_system_reset_n
);

  // ==========================================================================
  // State
  typedef struct packed {
    bus_state_t        state;
    logic              bus_clk;
    logic [1:0]        ready_sync;
    logic [1:0]        irq_sync;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    bus_pins_t         pins;
    logic              is_read;
    logic              exp_space;
    logic [BCNT_W-1:0] bclk_cnt;
    logic [TCNT_W-1:0] tmo_cnt;
    logic [DATA_W-1:0] rdata;
    logic              valid_pend;
    logic              valid_n;
    logic              done;
    logic              flag_n;
    logic              clr_prev;
    logic              rst_out_n;
  } state_t;

  state_t cur_q;
  state_t nxt_d;

  // Minimum bus clocks for a width code
  function automatic logic [BCNT_W-1:0] min_len(input logic [1:0] code);
    if (code == WIDTH_CODE_ZERO) begin
      min_len = WIDTH_ZERO_LEN; // see [RULE_13]
    end else begin
      min_len = {1'b0, code};
    end
  endfunction : min_len

  logic bus_tick;
  logic ready_seen;
  logic len_met;
  logic timed_out;

  // Bus clock rises when the divider phase goes from low to high
  assign bus_tick   = ~cur_q.bus_clk;
  // Floating READY reads high through the pull-up, which counts as done
  assign ready_seen = cur_q.ready_sync[1];                       // see [RULE_14]
  assign len_met    = (cur_q.bclk_cnt + 3'h1) >= min_len(i_min_width);
  assign timed_out  = (cur_q.tmo_cnt == TIMEOUT_CYC);

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_d = cur_q;
    nxt_d.done       = 1'b0;
    nxt_d.rst_out_n  = 1'b1;                                     // see [RULE_09]
    nxt_d.bus_clk    = ~cur_q.bus_clk;                           // see [RULE_10]
    nxt_d.ready_sync = {cur_q.ready_sync[0], i_ready};
    nxt_d.irq_sync   = {cur_q.irq_sync[0], i_irq_n};             // see [RULE_08]
    nxt_d.data_meta  = i_data;
    nxt_d.data_sync  = cur_q.data_meta;
    nxt_d.clr_prev   = i_bus_timeout_clear_n;
    // Data valid goes out one cycle after the latch
    nxt_d.valid_n    = ~cur_q.valid_pend;                        // see [RULE_11]
    nxt_d.valid_pend = 1'b0;

    if (cur_q.state == ST_IDLE) begin
      nxt_d.tmo_cnt = '0;
    end else if (!timed_out) begin
      nxt_d.tmo_cnt = cur_q.tmo_cnt + 10'h001;
    end

    // Clear flag on the low-to-high return of the clear control
    if (i_bus_timeout_clear_n && !cur_q.clr_prev) begin
      nxt_d.flag_n = 1'b1;                                       // see [RULE_12]
    end

    case (cur_q.state)
      ST_IDLE: begin
        if (i_req) begin
          nxt_d.state              = ST_SETUP;
          nxt_d.is_read            = ~i_req_info.wr;
          nxt_d.exp_space          = i_req_info.exp_space;
          nxt_d.bclk_cnt           = '0;
          nxt_d.pins.addr          = i_req_info.addr;
          nxt_d.pins.upper_byte_enable_n = ~i_req_info.upper_byte; // see [RULE_02]
          nxt_d.pins.data          = i_req_info.wdata;
          nxt_d.pins.data_oe       = i_req_info.wr;              // see [RULE_01]
        end
      end
      ST_SETUP: begin
        if (bus_tick) begin
          nxt_d.state = ST_STROBE;
          // Strobes only reach the connector for expansion space
          nxt_d.pins.rd_n = ~(cur_q.is_read & cur_q.exp_space);  // see [RULE_03]
          nxt_d.pins.wr_n = ~(~cur_q.is_read & cur_q.exp_space); // see [RULE_04]
        end
      end
      ST_STROBE: begin
        if (timed_out) begin
          nxt_d.state     = ST_HOLD;
          nxt_d.pins.rd_n = 1'b1;                                // see [RULE_12]
          nxt_d.pins.wr_n = 1'b1;
          nxt_d.flag_n    = 1'b0;
        end else if (bus_tick) begin
          // The first tick still sees READY and data from before the strobe fell
          if (len_met && (!cur_q.exp_space                       // see [RULE_06]
                          || (ready_seen && cur_q.bclk_cnt != '0))) begin // see [RULE_05]
            nxt_d.state     = ST_HOLD;
            nxt_d.pins.rd_n = 1'b1;
            nxt_d.pins.wr_n = 1'b1;
            if (cur_q.is_read) begin
              nxt_d.rdata      = cur_q.data_sync;                // see [RULE_01] [RULE_11]
              nxt_d.valid_pend = 1'b1;
            end
          end else if (!len_met || cur_q.bclk_cnt == '0) begin
            nxt_d.bclk_cnt = cur_q.bclk_cnt + 3'h1;              // see [RULE_13]
          end
        end
      end
      ST_HOLD: begin
        // Address and data held one more bus clock past the strobe
        if (bus_tick) begin
          nxt_d.state        = ST_IDLE;                          // see [RULE_15]
          nxt_d.pins.data_oe = 1'b0;
          nxt_d.done         = 1'b1;
        end
      end
      default: begin
        nxt_d.state     = ST_IDLE;
        nxt_d.pins.rd_n = 1'b1;
        nxt_d.pins.wr_n = 1'b1;
      end
    endcase

    // A timeout in the same cycle as the clear wins
    if (cur_q.state == ST_STROBE && timed_out) begin
      nxt_d.flag_n = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_q.state      <= ST_IDLE;
      cur_q.bus_clk    <= 1'b0;
      cur_q.ready_sync <= 2'h0;
      cur_q.irq_sync   <= 2'h3;
      cur_q.data_meta  <= DATA_RST;
      cur_q.data_sync  <= DATA_RST;
      cur_q.pins.addr  <= ADDR_RST;
      cur_q.pins.upper_byte_enable_n <= 1'b1;
      cur_q.pins.rd_n  <= 1'b1;
      cur_q.pins.wr_n  <= 1'b1;
      cur_q.pins.data  <= DATA_RST;
      cur_q.pins.data_oe <= 1'b0;
      cur_q.is_read    <= 1'b0;
      cur_q.exp_space  <= 1'b0;
      cur_q.bclk_cnt   <= '0;
      cur_q.tmo_cnt    <= '0;
      cur_q.rdata      <= DATA_RST;
      cur_q.valid_pend <= 1'b0;
      cur_q.valid_n    <= 1'b1;
      cur_q.done       <= 1'b0;
      cur_q.flag_n     <= 1'b1;
      cur_q.clr_prev   <= 1'b1;
      cur_q.rst_out_n  <= 1'b0;                                  // see [RULE_09]
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_busy                         = (cur_q.state != ST_IDLE);
  assign o_done                         = cur_q.done;
  assign o_rdata                        = cur_q.rdata;
  assign o_cpu_data_valid_n             = cur_q.valid_n;
  assign o_bus_timeout_flag_n           = cur_q.flag_n;
  assign o_cpu_maskable_irq_input_two_n = cur_q.irq_sync[1];     // see [RULE_08]
  assign o_pins                         = cur_q.pins;
  assign o_local_bus_clock              = cur_q.bus_clk;
  assign o_system_reset_n               = cur_q.rst_out_n;

endmodule : local_expansion_bus_master

`default_nettype wire

// ==== tb/exp_device_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module exp_device_model
  import local_expansion_bus_pkg::*;
(
  // Bus side
  input  wire logic              i_clk,
  input  var  bus_pins_t         i_pins,
  // Behaviour control
  input  wire logic [7:0]        i_wait,
  input  wire logic              i_stall,
  // Answers
  output logic [DATA_W-1:0]      o_data,
  output logic                   o_ready
);
  logic [7:0]        cnt_q = 8'h00;
  logic [DATA_W-1:0] word_q = 16'hA5A5;
  logic              sel;
  assign sel = !(i_pins.rd_n && i_pins.wr_n);
  always_ff @(posedge i_clk) begin
    cnt_q <= !sel ? 8'h00 : (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
    if (!i_pins.wr_n) begin
      word_q <= i_pins.data;
    end
  end
  // Ready stays up until the strobe goes; idle line sits at the pull-up
  assign o_ready = !i_stall && (!sel || cnt_q >= i_wait);
  // Released data lines float to the pull-up level
  assign o_data = !i_pins.rd_n ? word_q : 16'hFFFF;
endmodule : exp_device_model
`default_nettype wire

// ==== tb/local_expansion_bus_master_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module local_expansion_bus_master_tb_top;
  import local_expansion_bus_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b1, req = 1'b0, clr_n = 1'b1, irq_n = 1'b1, stall = 1'b0;
  logic busy, done, valid_n, flag_n, irq2_n, local_bus_clock, sysrst_n, ready;
  logic [1:0]  width = 2'h1;
  logic [7:0]  wait_c = 8'h00;
  logic [15:0] rdata, data, last = 16'hA5A5;
  logic [31:0] rs = 32'h00016E16, r, r2;
  bus_req_t    info = '0;
  bus_pins_t   pins;
  int          miscompares = 0, compares = 0, lowc = 0, l0;
  local_expansion_bus_master u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req),
    .i_req_info(info), .i_min_width(width), .i_bus_timeout_clear_n(clr_n), .o_busy(busy),
    .o_done(done), .o_rdata(rdata), .o_cpu_data_valid_n(valid_n), .o_bus_timeout_flag_n(flag_n),
    .o_cpu_maskable_irq_input_two_n(irq2_n), .o_pins(pins), .i_data(data), .i_ready(ready),
    .i_irq_n(irq_n), .o_local_bus_clock(local_bus_clock), .o_system_reset_n(sysrst_n));
  exp_device_model u_dev (.i_clk(i_clk), .i_pins(pins), .i_wait(wait_c), .i_stall(stall),
    .o_data(data), .o_ready(ready));
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (!(pins.rd_n && pins.wr_n)) lowc <= lowc + 1;
  // ====================
  // Helpers
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic int strobe_cycles(input logic [1:0] c);
    // Expansion strobes last two bus clocks at least: READY is trusted from the second
    return 2 * ((c == 2'h0) ? 4 : (c == 2'h1) ? 2 : int'(c));
  endfunction : strobe_cycles
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic acc(input logic wr, ex, ub, input logic [19:0] a, input logic [15:0] d,
                     input logic [1:0] w);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= 1'b1;
    info <= '{wr: wr, exp_space: ex, upper_byte: ub, addr: a, wdata: d};
    width <= w;
    @(posedge i_clk);
    req <= 1'b0;
    do begin
      @(negedge i_clk);
      n++;
    end while (done !== 1'b1 && n < 600);
    if (n >= 600) begin
      miscompares++;
      test_done();
    end
    `CHK("busy", 1'b0, busy)
    if (ex && wr) last = d;
    if (ex && !wr) `CHK("rdata", last, rdata)
  endtask : acc
  // ====================
  // Sequence
  initial begin
    i_resetn <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK("sysrst_n", 1'b1, sysrst_n)
    for (int c = 0; c < 4; c++) begin
      l0 = lowc;
      acc(1'b0, 1'b1, 1'b1, 20'hFFFFF, 16'h0000, c[1:0]);
      `CHK("strobe_len", strobe_cycles(c[1:0]), lowc - l0)
    end
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      r2 = rnd();
      @(posedge i_clk);
      wait_c <= {5'h00, r[8:6]};
      irq_n <= r[9];
      l0 = lowc;
      acc(r[0], r[1] | r[2], r[3], r[31:12], r2[15:0], r[5:4]);
      `CHK("irq_two_n", irq_n, irq2_n)
      if (r[1] | r[2]) begin
        `CHK("ready_wait", 1'b1, (lowc - l0) >= int'(wait_c) + 3)
      end else begin
        `CHK("no_strobe", 0, lowc - l0)
      end
    end
    @(posedge i_clk);
    stall <= 1'b1;
    l0 = lowc;
    acc(1'b0, 1'b0, 1'b0, 20'h00010, 16'h1234, 2'h1);
    `CHK("no_strobe", l0, lowc)
    `CHK("flag_n", 1'b1, flag_n)
    acc(1'b1, 1'b1, 1'b0, 20'h80000, 16'hC3C3, 2'h1);
    `CHK("flag_n", 1'b0, flag_n)
    @(posedge i_clk);
    stall <= 1'b0;
    clr_n <= 1'b0;
    @(posedge i_clk);
    clr_n <= 1'b1;
    repeat (3) @(negedge i_clk);
    `CHK("flag_n", 1'b1, flag_n)
    acc(1'b0, 1'b1, 1'b0, 20'h00002, 16'h0000, 2'h2);
    test_done();
  end
endmodule : local_expansion_bus_master_tb_top
`default_nettype wire

// ==== tb/local_expansion_bus_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module local_expansion_bus_props
  import local_expansion_bus_pkg::*;
(
  // Clock and reset
  input wire logic      i_clk,
  input wire logic      i_resetn,
  // Observed ports
  input wire logic      i_req,
  input var  bus_req_t  i_req_info,
  input wire logic      i_bus_timeout_clear_n,
  input wire logic      i_ready,
  input wire logic      i_irq_n,
  input wire logic      o_busy,
  input wire logic      o_cpu_data_valid_n,
  input wire logic      o_bus_timeout_flag_n,
  input wire logic      o_cpu_maskable_irq_input_two_n,
  input var  bus_pins_t o_pins,
  input wire logic      o_local_bus_clock,
  input wire logic      o_system_reset_n
);
  // ====================
  // Access kind captured when a request is taken
  logic       ex_q, wr_q, ub_q;
  logic [9:0] cnt_q;
  logic [ADDR_W-1:0] a_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {ex_q, wr_q, ub_q} <= 3'h0;
      a_q <= '0;
      cnt_q <= 10'h000;
    end else begin
      if (i_req && !o_busy) begin
        {ex_q, wr_q, ub_q} <= {i_req_info.exp_space, i_req_info.wr, i_req_info.upper_byte};
        a_q <= i_req_info.addr;
      end
      cnt_q <= o_busy ? cnt_q + 10'h001 : 10'h000;
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  rd_space_a: assert property (!o_pins.rd_n |-> ex_q && !wr_q) else $error("Bad read strobe");
  wr_space_a: assert property (!o_pins.wr_n |-> ex_q && wr_q) else $error("Bad write strobe");
  ube_lane_a: assert property (!(o_pins.rd_n && o_pins.wr_n)
    |-> o_pins.upper_byte_enable_n == !ub_q) else $error("Bad byte enable");
  addr_value_a: assert property (!(o_pins.rd_n && o_pins.wr_n)
    |-> o_pins.addr == a_q) else $error("Bad strobe address");
  data_dir_a: assert property (!(o_pins.rd_n && o_pins.wr_n)
    |-> o_pins.data_oe == wr_q) else $error("Bad data direction");
  pins_hold_a: assert property (!(o_pins.rd_n && o_pins.wr_n) && $stable(o_pins.rd_n)
    && $stable(o_pins.wr_n) |-> $stable(o_pins.addr) && $stable(o_pins.data)
    && $stable(o_pins.upper_byte_enable_n)) else $error("Pins moved in strobe");
  clk_half_a: assert property ($past(i_resetn) |-> o_local_bus_clock != $past(o_local_bus_clock))
    else $error("Bus clock not halved");
  sys_reset_a: assert property (disable iff (1'b0) !i_resetn |-> !o_system_reset_n)
    else $error("System reset high");
  rd_valid_a: assert property ($rose(o_pins.rd_n) && !$fell(o_bus_timeout_flag_n)
    |=> !o_cpu_data_valid_n ##1 o_cpu_data_valid_n) else $error("Valid pulse wrong");
  ready_end_a: assert property (($rose(o_pins.rd_n) || $rose(o_pins.wr_n))
    && !$fell(o_bus_timeout_flag_n) |-> $past(i_ready, 3) || $past(i_ready, 4))
    else $error("Strobe ended without ready");
  busy_max_a: assert property (cnt_q <= 10'h19A) else $error("Cycle not aborted");
  flag_clr_a: assert property ($rose(i_bus_timeout_clear_n) && !o_busy
    |-> ##[1:2] o_bus_timeout_flag_n) else $error("Flag not cleared");
  irq_pass_a: assert property (($stable(i_irq_n))[*3]
    |-> o_cpu_maskable_irq_input_two_n == i_irq_n) else $error("Interrupt not passed");
endmodule : local_expansion_bus_props
bind local_expansion_bus_master local_expansion_bus_props u_props (.i_clk, .i_resetn, .i_req,
  .i_req_info, .i_bus_timeout_clear_n, .i_ready, .i_irq_n, .o_busy, .o_cpu_data_valid_n,
  .o_bus_timeout_flag_n, .o_cpu_maskable_irq_input_two_n, .o_pins, .o_local_bus_clock,
  .o_system_reset_n);
`default_nettype wire
